// ===== rtl/cpwf_pkg.sv
// Shared constants and types of the poll/write frame interpreter.
// Assumes one 40 MHz clock; bytes move as whole octets with a last flag.
package cpwf_pkg;

   // Frame framing: preamble length, sync word and the smallest length byte.
   localparam logic [7:0] PRE_BYTE = 8'h00;
   localparam logic [2:0] PRE_LEN = 3'h6;
   localparam logic [7:0] SYNC_HI = 8'hb2;
   localparam logic [7:0] SYNC_LO = 8'h4d;
   localparam logic [7:0] LEN_MIN = 8'h02;

   // Length bytes; they count the whole information field, length byte included.
   localparam logic [7:0] LEN_POLL = 8'h06;
   localparam logic [7:0] LEN_ANS = 8'h12;
   localparam logic [7:0] LEN_WR = 8'h44;
   localparam logic [7:0] LEN_WRSP = 8'h0c;

   // Command and response codes.
   localparam logic [7:0] CMD_POLL = 8'h00;
   localparam logic [7:0] CMD_ANS = 8'h01;
   localparam logic [7:0] CMD_WR = 8'h08;
   localparam logic [7:0] CMD_WRSP = 8'h09;

   // Field values checked or sent by the interpreter.
   localparam logic [15:0] SEL_ANY = 16'hffff;
   localparam logic [7:0] SLOT_ONLY = 8'h00;
   localparam logic [15:0] SVC_SYS = 16'h0900;
   localparam logic [47:0] BLK_LIST = 48'h801d_801e_801f;
   localparam logic [63:0] TDESC = 64'hffff_0000_00ff_ffff;
   localparam logic [15:0] STAT_OK = 16'h0000;
   localparam logic [15:0] STAT_ERR = 16'hff01;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [15:0] CRC_POLY = 16'h1021;

   // Byte positions inside a received information field.
   localparam int IX_CMD = 1;
   localparam int IX_SEL = 2;
   localparam int IX_SLOT = 5;
   localparam int IX_ID = 2;
   localparam int IX_SVC = 11;
   localparam int IX_LIST = 14;
   localparam int HDR_N = 20;

   // System area: three 16-byte blocks, selector and identifier offsets.
   localparam int AREA_N = 48;
   localparam int AR_SEL = 16;
   localparam int AR_ID = 18;

   // Transmit byte positions and first status byte of a response.
   localparam logic [6:0] TX_SYNC_IX = 7'h06;
   localparam logic [6:0] TX_INFO_IX = 7'h08;
   localparam logic [6:0] RSP_TAIL = 7'h0a;

   // One byte of a frame with its end-of-frame marker.
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } cpwf_byte_s;

   typedef enum logic [5:0] {
      ST_HUNT = 6'h01,
      ST_SYNC = 6'h02,
      ST_BODY = 6'h04,
      ST_CRCB = 6'h08,
      ST_EXEC = 6'h10,
      ST_SEND = 6'h20
   } cpwf_st_e;

endpackage : cpwf_pkg

// ===== rtl/cpwf_crc16.sv
// Byte-wise CRC-16 step, purely combinational.
// Assumes the caller holds the running value in its own register.
`timescale 1ns/1ps
module cpwf_crc16 #(
   parameter logic [15:0] POLY = cpwf_pkg::CRC_POLY
) (
   input wire logic [15:0] crc_i,
   input wire logic [7:0] byte_i,
   output logic [15:0] crc_o
);
   import cpwf_pkg::*;

   // Eight shift steps, most significant bit first.
   always_comb
   begin
      logic [15:0] c;
      c = crc_i ^ {byte_i, 8'h00};
      for (int k = 0; k < 8; k++)
      begin
         c = c[15] ? ({c[14:0], 1'b0} ^ POLY) : {c[14:0], 1'b0};
      end
      crc_o = c;
   end

endmodule : cpwf_crc16

// ===== rtl/cpwf_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two so that the pointers wrap naturally.
`timescale 1ns/1ps
module cpwf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   import cpwf_pkg::*;
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } cpwf_fifo_s;

   cpwf_fifo_s q;
   cpwf_fifo_s d;
   logic wr;
   logic rd;

   // Full and empty come from the count, so they are exact every cycle.
   assign in_ready_o = q.cnt != (AW + 1)'(DEPTH);
   assign out_valid_o = q.cnt != '0;
   assign out_data_o = q.mem[q.rp];
   assign wr = in_valid_i && in_ready_o;
   assign rd = out_valid_o && out_ready_i;

   // Next state of storage, pointers and count.
   always_comb
   begin
      d = q;
      if (wr)
      begin
         d.mem[q.wp] = in_data_i;
         d.wp = q.wp + 1'b1;
      end
      if (rd)
      begin
         d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW + 1)'(wr) - (AW + 1)'(rd);
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : cpwf_fifo

// ===== rtl/cpwf_poll_write.sv
// Frame interpreter of the tag's proximity link: answers polls, takes
// system-area writes and returns their result, one frame at a time.
// Assumes received bytes arrive synchronous to sys_clk_i with a last flag
// on the final CRC byte, and that the radio layer drains tx_o.
`timescale 1ns/1ps
module cpwf_poll_write #(
   parameter logic [15:0] SEL_RST = 16'haaff,
   parameter logic [63:0] ID_RST = 64'h0011_2233_4455_6677 // Arbitrary value.
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input cpwf_pkg::cpwf_byte_s rx_i,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   output cpwf_pkg::cpwf_byte_s tx_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [cpwf_pkg::AREA_N-1:0][7:0] area_o,
   output logic area_written_o
);
   import cpwf_pkg::*;

   typedef struct packed {
      cpwf_st_e st;
      logic [2:0] zcnt;
      logic [6:0] idx;
      logic [7:0] len;
      logic [15:0] crc;
      logic [7:0] crc_hi;
      logic [HDR_N-1:0][7:0] hdr;
      logic [AREA_N-1:0][7:0] stage;
      logic [AREA_N-1:0][7:0] area;
      logic is_wr;
      logic [7:0] tx_len;
      logic [15:0] status;
      logic commit;
      logic rx_rdy;
      cpwf_byte_s txb;
      logic txv;
   } cpwf_state_s;

   // Builds the reset image of the system area from the two parameters.
   function automatic logic [AREA_N-1:0][7:0] area_init(logic [15:0] sel, logic [63:0] id);
      logic [AREA_N-1:0][7:0] a;
      a = '0;
      a[AR_SEL] = sel[15:8];
      a[AR_SEL+1] = sel[7:0];
      for (int k = 0; k < 8; k++)
      begin
         a[AR_ID+k] = id[63-8*k -: 8];
      end
      return a;
   endfunction : area_init

   // Configured identifier, first byte on the air in the top bits.
   function automatic logic [63:0] cfg_id(logic [AREA_N-1:0][7:0] a);
      logic [63:0] r;
      r = '0;
      for (int k = 0; k < 8; k++)
      begin
         r[63-8*k -: 8] = a[AR_ID+k];
      end
      return r;
   endfunction : cfg_id

   // Identifier echoed in a received frame.
   function automatic logic [63:0] hdr_id(logic [HDR_N-1:0][7:0] h);
      logic [63:0] r;
      r = '0;
      for (int k = 0; k < 8; k++)
      begin
         r[63-8*k -: 8] = h[IX_ID+k];
      end
      return r;
   endfunction : hdr_id

   // Information byte j of the answer being sent.
   function automatic logic [7:0] resp_byte(logic wr, logic [6:0] j, logic [63:0] id,
                                            logic [15:0] st);
      logic [7:0][7:0] idb;
      logic [7:0][7:0] tdb;
      logic [7:0] r;
      idb = id;
      tdb = TDESC;
      r = '0;
      if (j == 7'h00)
         r = wr ? LEN_WRSP : LEN_ANS;
      else if (j == 7'h01)
         r = wr ? CMD_WRSP : CMD_ANS;
      else if (j < RSP_TAIL)
         r = idb[3'(RSP_TAIL - 7'h01 - j)];
      else if (wr)
         r = (j == RSP_TAIL) ? st[15:8] : st[7:0];
      else
         r = tdb[3'(RSP_TAIL + 7'h07 - j)];
      return r;
   endfunction : resp_byte

   localparam logic [AREA_N-1:0][7:0] AREA_RST = area_init(SEL_RST, ID_RST);

   cpwf_state_s q;
   cpwf_state_s d;
   cpwf_byte_s tx_byte;
   cpwf_byte_s f_out;
   logic f_vld;
   logic f_rdy;
   logic push;
   logic take;
   logic [6:0] info_end;
   logic [7:0] lenv;
   logic [7:0] crc_byte;
   logic [15:0] crc_nx;
   logic [15:0] sel_rx;
   logic poll_ok;
   logic wr_ok;
   logic blk_ok;

   // Frame decode; the extra-information byte is never looked at, so every
   // answered poll goes out without added data.
   assign take = rx_valid_i && q.rx_rdy;
   assign sel_rx = {q.hdr[IX_SEL], q.hdr[IX_SEL+1]};
   assign poll_ok = q.len == LEN_POLL && q.hdr[IX_CMD] == CMD_POLL
      && q.hdr[IX_SLOT] == SLOT_ONLY
      && (sel_rx == SEL_ANY || sel_rx == {q.area[AR_SEL], q.area[AR_SEL+1]});
   assign wr_ok = q.len == LEN_WR && q.hdr[IX_CMD] == CMD_WR
      && hdr_id(q.hdr) == cfg_id(q.area);
   // The list is compared byte by byte in arrival order; a packed slice would
   // put the last received byte on top and reverse the list.
   assign blk_ok = {q.hdr[IX_SVC], q.hdr[IX_SVC+1]} == SVC_SYS
      && {q.hdr[IX_LIST], q.hdr[IX_LIST+1], q.hdr[IX_LIST+2], q.hdr[IX_LIST+3],
          q.hdr[IX_LIST+4], q.hdr[IX_LIST+5]} == BLK_LIST;
   assign lenv = (q.idx == '0) ? rx_i.data : q.len;
   assign info_end = TX_INFO_IX + 7'(q.tx_len);

   // Outgoing byte for the current transmit position.
   always_comb
   begin
      tx_byte.last = q.idx == info_end + 7'h01;
      if (q.idx < TX_SYNC_IX)
         tx_byte.data = PRE_BYTE;
      else if (q.idx == TX_SYNC_IX)
         tx_byte.data = SYNC_HI;
      else if (q.idx == TX_SYNC_IX + 7'h01)
         tx_byte.data = SYNC_LO;
      else if (q.idx < info_end)
         tx_byte.data = resp_byte(q.is_wr, q.idx - TX_INFO_IX, cfg_id(q.area), q.status);
      else if (q.idx == info_end)
         tx_byte.data = q.crc[15:8];
      else
         tx_byte.data = q.crc[7:0];
   end

   // One CRC engine serves both directions; they never overlap.
   assign crc_byte = (q.st == ST_SEND) ? tx_byte.data : rx_i.data;

   cpwf_crc16 #(.POLY(CRC_POLY)) u_crc (
      .crc_i(q.crc),
      .byte_i(crc_byte),
      .crc_o(crc_nx)
   );

   // Frame hunting, reception, decision and answer generation.
   always_comb
   begin
      d = q;
      d.commit = 1'b0;
      push = 1'b0;
      unique case (q.st)
         ST_HUNT:
         begin
            if (take && rx_i.data == PRE_BYTE)
               d.zcnt = (q.zcnt == PRE_LEN) ? q.zcnt : q.zcnt + 3'h1;
            else if (take)
            begin
               d.zcnt = '0;
               if (rx_i.data == SYNC_HI && q.zcnt == PRE_LEN)
                  d.st = ST_SYNC;
            end
         end
         ST_SYNC:
         begin
            if (take)
            begin
               d.idx = '0;
               d.crc = CRC_INIT;
               d.st = (rx_i.data == SYNC_LO && !rx_i.last) ? ST_BODY : ST_HUNT;
            end
         end
         ST_BODY:
         begin
            if (take)
            begin
               d.crc = crc_nx;
               d.len = lenv;
               if (q.idx < 7'(HDR_N))
                  d.hdr[q.idx] = rx_i.data;
               else
                  d.stage[6'(q.idx - 7'(HDR_N))] = rx_i.data;
               if (rx_i.last || lenv < LEN_MIN || lenv > LEN_WR)
                  d.st = ST_HUNT;
               else if (q.idx == 7'(lenv - 8'h01))
               begin
                  d.st = ST_CRCB;
                  d.idx = '0;
               end
               else
                  d.idx = q.idx + 7'h01;
            end
         end
         ST_CRCB:
         begin
            if (take && q.idx == '0)
            begin
               d.crc_hi = rx_i.data;
               d.idx = 7'h01;
               if (rx_i.last)
                  d.st = ST_HUNT;
            end
            else if (take)
            begin
               // A missing last flag means the frame ran longer than its length.
               if (!rx_i.last || {q.crc_hi, rx_i.data} != q.crc)
                  d.st = ST_HUNT;
               else
               begin
                  d.st = ST_EXEC;
                  d.rx_rdy = 1'b0;
               end
            end
         end
         ST_EXEC:
         begin
            d.idx = '0;
            d.crc = CRC_INIT;
            d.st = ST_SEND;
            if (poll_ok)
            begin
               d.is_wr = 1'b0;
               d.tx_len = LEN_ANS;
            end
            else if (wr_ok)
            begin
               d.is_wr = 1'b1;
               d.tx_len = LEN_WRSP;
               d.status = blk_ok ? STAT_OK : STAT_ERR;
               if (blk_ok)
               begin
                  d.area = q.stage;
                  d.commit = 1'b1;
               end
            end
            else
            begin
               d.st = ST_HUNT;
               d.rx_rdy = 1'b1;
            end
         end
         ST_SEND:
         begin
            // The FIFO's ready holds the sequencer, so nothing is dropped.
            if (f_rdy)
            begin
               push = 1'b1;
               if (q.idx >= TX_INFO_IX && q.idx < info_end)
                  d.crc = crc_nx;
               d.idx = q.idx + 7'h01;
               if (tx_byte.last)
               begin
                  d.st = ST_HUNT;
                  d.rx_rdy = 1'b1;
                  d.idx = '0;
               end
            end
         end
      endcase
      if (!q.txv || tx_ready_i)
      begin
         d.txv = f_vld;
         d.txb = f_out;
      end
      d.zcnt = (d.st == ST_HUNT) ? d.zcnt : '0;
   end

   cpwf_fifo #(.WIDTH($bits(cpwf_byte_s)), .DEPTH(16)) u_fifo (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .in_data_i(tx_byte),
      .in_valid_i(push),
      .in_ready_o(f_rdy),
      .out_data_o(f_out),
      .out_valid_o(f_vld),
      .out_ready_i(!q.txv || tx_ready_i)
   );

   // State register; the system area restarts from the parameter image.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         q <= '{st: ST_HUNT, area: AREA_RST, rx_rdy: 1'b1, default: '0};
      else
         q <= d;
   end

   assign rx_ready_o = q.rx_rdy;
   assign tx_o = q.txb;
   assign tx_valid_o = q.txv;
   assign area_o = q.area;
   assign area_written_o = q.commit;

   property p_pre;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      push && q.idx < TX_SYNC_IX |-> tx_byte.data == 8'h00;
   endproperty
   a_pre: assert property (p_pre) else $error("preamble byte not zero");

   property p_sync;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      push && (q.idx == 7'h06 || q.idx == 7'h07)
         |-> tx_byte.data == ((q.idx == 7'h06) ? 8'hb2 : 8'h4d);
   endproperty
   a_sync: assert property (p_sync) else $error("sync word broken");

   property p_len;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      push && q.idx == 7'h08 |-> tx_byte.data == (q.is_wr ? 8'h0c : 8'h12);
   endproperty
   a_len: assert property (p_len) else $error("wrong length byte");

   property p_ans;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      push && q.idx == 7'h09 && !q.is_wr |-> tx_byte.data == 8'h01;
   endproperty
   a_ans: assert property (p_ans) else $error("poll answer code wrong");

   property p_wrsp;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      push && q.idx == 7'h09 && q.is_wr |-> tx_byte.data == 8'h09;
   endproperty
   a_wrsp: assert property (p_wrsp) else $error("write answer code wrong");

   property p_drop;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      q.st == ST_CRCB && take && q.idx == 7'h01 && {q.crc_hi, rx_i.data} != q.crc
         |=> q.st == ST_HUNT ##1 !push [*3];
   endproperty
   a_drop: assert property (p_drop) else $error("bad frame answered");

   property p_reply;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      q.st == ST_EXEC && wr_ok |=> q.st == ST_SEND && q.is_wr ##[1:40] push;
   endproperty
   a_reply: assert property (p_reply) else $error("write not answered");

   property p_id;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      area_written_o |-> $past(hdr_id(q.hdr)) == $past(cfg_id(q.area)) && $past(blk_ok);
   endproperty
   a_id: assert property (p_id) else $error("write with foreign identifier");

   property p_slot;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      q.st == ST_EXEC && q.hdr[IX_SLOT] != 8'h00 && q.hdr[IX_CMD] == 8'h00 |=> q.st == ST_HUNT;
   endproperty
   a_slot: assert property (p_slot) else $error("poll in other slot answered");

   property p_any;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      q.st == ST_EXEC && q.len == 8'h06 && q.hdr[IX_CMD] == 8'h00 && q.hdr[IX_SLOT] == 8'h00
         && sel_rx == 16'hffff |=> q.st == ST_SEND && !q.is_wr;
   endproperty
   a_any: assert property (p_any) else $error("wildcard poll ignored");

endmodule : cpwf_poll_write

// ===== tb/cpwf_reader.sv
// Reader model: sends complete frames byte by byte and drains the tag's answers.
// Assumes the bench builds each frame and raises stall_i to hold answers back.
`timescale 1ns/1ps
module cpwf_reader (
   input wire logic sys_clk_i,
   input wire logic stall_i,
   input wire logic rx_ready_i,
   output cpwf_pkg::cpwf_byte_s rx_o,
   output logic rx_valid_o,
   output logic tx_ready_o
);
   import cpwf_pkg::*;

   logic [1:0] pace_q;
   int n_lost;

   // Idle line levels at time zero.
   initial
   begin
      rx_o = '0;
      rx_valid_o = 1'b0;
      tx_ready_o = 1'b0;
      pace_q = 2'h0;
      n_lost = 0;
   end

   // Drain one cycle in four slowly, so the tag's output holding is exercised too.
   always @(negedge sys_clk_i)
   begin
      pace_q <= pace_q + 2'h1;
      tx_ready_o <= !stall_i && (pace_q != 2'h3);
   end

   // Each byte stands until the tag takes it or 200 cycles pass; the line is scrambled once released.
   task automatic send(input logic [7:0] f[$]);
      int i;
      int w;
      for (i = 0; i < f.size(); i++)
      begin
         @(negedge sys_clk_i);
         rx_o <= '{last: (i == f.size() - 1), data: f[i]};
         rx_valid_o <= 1'b1;
         w = 0;
         do
         begin
            @(posedge sys_clk_i);
            w++;
         end while (!rx_ready_i && w < 200);
         if (!rx_ready_i) n_lost++;
      end
      @(negedge sys_clk_i);
      rx_valid_o <= 1'b0;
      rx_o <= ~rx_o;
   endtask : send
endmodule : cpwf_reader

// ===== tb/test_contactless_poll_write_frames.sv
// Bench of the poll/write frame interpreter against a reader model.
// Assumes the package constants and the hand-over timing of the receive and answer links.
`timescale 1ns/1ps
module test_contactless_poll_write_frames;
   import cpwf_pkg::*;

   localparam logic [63:0] ID_DEF = 64'h0011_2233_4455_6677; // Arbitrary value.
   localparam logic [15:0] SEL_DEF = 16'haaff;
   localparam logic [15:0] SEL_NEW = 16'h1234;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic stall = 1'b0;
   cpwf_byte_s rx;
   cpwf_byte_s tx;
   logic rx_valid, rx_ready, tx_valid, tx_ready, area_written;
   logic [AREA_N-1:0][7:0] area, area_e, area_n;
   cpwf_byte_s exp_q[$];
   logic [7:0] inf[$];
   logic [7:0] frm[$];
   logic [31:0] rnd_q = 32'ha581;
   int n_errors = 0;
   int total_checks = 0;
   int n_pulses = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   cpwf_poll_write #(.SEL_RST(SEL_DEF), .ID_RST(ID_DEF)) cpwf_poll_write_i (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .rx_i(rx), .rx_valid_i(rx_valid),
      .rx_ready_o(rx_ready), .tx_o(tx), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .area_o(area), .area_written_o(area_written));

   cpwf_reader cpwf_reader_i (
      .sys_clk_i(sys_clk_i), .stall_i(stall), .rx_ready_i(rx_ready), .rx_o(rx),
      .rx_valid_o(rx_valid), .tx_ready_o(tx_ready));

   // Case-equal comparison, so an unknown never passes.
   task automatic check(input string what, input logic [383:0] e, input logic [383:0] s);
      total_checks++;
      if (e !== s)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask : check

   task automatic give_verdict;
      $display("Checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   // Bitwise CRC kept apart from the design's own byte step.
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (q[i])
      begin
         c = c ^ {q[i], 8'h00};
         repeat (8) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc16

   task automatic put(input logic [63:0] v, input int n);
      for (int k = n - 1; k >= 0; k--) inf.push_back(v[k*8+:8]);
   endtask : put

   // Wraps inf in preamble, sync word and CRC; bad spoils the CRC on purpose.
   task automatic build(input bit bad);
      logic [15:0] c;
      c = crc16(inf) ^ {15'h0, bad};
      frm = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, SYNC_HI, SYNC_LO};
      foreach (inf[i]) frm.push_back(inf[i]);
      frm.push_back(c[15:8]);
      frm.push_back(c[7:0]);
   endtask : build

   task automatic note_answer;
      build(1'b0);
      foreach (frm[i]) exp_q.push_back('{last: (i == frm.size() - 1), data: frm[i]});
   endtask : note_answer

   task automatic poll(input logic [15:0] sel, input logic [7:0] slot, input logic [7:0] len,
                       input bit bad, input bit answered);
      if (answered)
      begin
         inf = '{LEN_ANS, CMD_ANS};
         put(ID_DEF, 8);
         put(TDESC, 8);
         note_answer();
      end
      inf = '{len, CMD_POLL, sel[15:8], sel[7:0], 8'h00, slot};
      build(bad);
      cpwf_reader_i.send(frm);
   endtask : poll

   task automatic write(input logic [63:0] id, input logic [15:0] svc, input logic [15:0] st,
                        input bit answered);
      if (answered)
      begin
         inf = '{LEN_WRSP, CMD_WRSP};
         put(id, 8);
         put({48'h0, st}, 2);
         note_answer();
      end
      inf = '{LEN_WR, CMD_WR};
      put(id, 8);
      inf.push_back(8'h01);
      put({48'h0, svc}, 2);
      inf.push_back(8'h01);
      put({16'h0, BLK_LIST}, 6);
      for (int k = 0; k < AREA_N; k++) inf.push_back(area_n[k]);
      build(1'b0);
      cpwf_reader_i.send(frm);
   endtask : write

   // Waits for all noted answers, then idles long enough to catch a stray one.
   task automatic settle;
      int w;
      w = 0;
      while ((exp_q.size() != 0 || rx_ready !== 1'b1) && w < 500)
      begin
         @(posedge sys_clk_i);
         w++;
      end
      if (w >= 500)
      begin
         n_errors++;
         $display("Error answer wait expected done seen timeout");
         give_verdict();
      end
      repeat (30) @(posedge sys_clk_i);
   endtask : settle

   // Takes the oldest noted byte whenever an answer byte is consumed.
   always @(posedge sys_clk_i)
   begin
      if (area_written === 1'b1) n_pulses++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unexpected answer byte", 384'h0, 384'(tx) | 384'h200);
         else
            check("answer byte", 384'(exp_q.pop_front()), 384'(tx));
      end
   end

   // Main sequence: polls, refused frames, a stalled write, then a refused service.
   initial
   begin
      area_e = '0;
      area_e[16] = SEL_DEF[15:8];
      area_e[17] = SEL_DEF[7:0];
      for (int k = 0; k < 8; k++) area_e[18+k] = ID_DEF[63-8*k-:8];
      repeat (6) @(negedge sys_clk_i);
      nrst_i = 1'b1;
      check("area at reset", area_e, area);
      check("ready at reset", 384'h1, 384'({rx_ready, tx_valid, area_written}) >> 2);
      poll(SEL_ANY, SLOT_ONLY, LEN_POLL, 1'b0, 1'b1);
      settle();
      poll(SEL_DEF, SLOT_ONLY, LEN_POLL, 1'b0, 1'b1);
      poll(SEL_NEW, SLOT_ONLY, LEN_POLL, 1'b0, 1'b0);
      poll(SEL_ANY, 8'h01, LEN_POLL, 1'b0, 1'b0);
      poll(SEL_ANY, SLOT_ONLY, LEN_POLL, 1'b1, 1'b0);
      poll(SEL_ANY, SLOT_ONLY, 8'h07, 1'b0, 1'b0);
      poll(SEL_ANY, SLOT_ONLY, 8'h05, 1'b0, 1'b0);
      settle();
      for (int k = 0; k < AREA_N; k++)
      begin
         rnd_q = {rnd_q[30:0], rnd_q[31] ^ rnd_q[21] ^ rnd_q[1] ^ rnd_q[0]};
         area_n[k] = rnd_q[7:0];
      end
      area_n[16] = SEL_NEW[15:8];
      area_n[17] = SEL_NEW[7:0];
      for (int k = 0; k < 8; k++) area_n[18+k] = ID_DEF[63-8*k-:8];
      write(ID_DEF ^ 64'h1, SVC_SYS, STAT_OK, 1'b0);
      settle();
      check("area after foreign write", area_e, area);
      stall <= 1'b1;
      write(ID_DEF, SVC_SYS, STAT_OK, 1'b1);
      repeat (60) @(negedge sys_clk_i);
      stall <= 1'b0;
      settle();
      check("area after write", area_n, area);
      check("write pulses", 384'h1, 384'(n_pulses));
      poll(SEL_NEW, SLOT_ONLY, LEN_POLL, 1'b0, 1'b1);
      poll(SEL_DEF, SLOT_ONLY, LEN_POLL, 1'b0, 1'b0);
      write(ID_DEF, 16'h0901, STAT_ERR, 1'b1);
      settle();
      check("area after refused service", area_n, area);
      check("write pulses", 384'h1, 384'(n_pulses));
      check("bytes not taken", 384'h0, 384'(cpwf_reader_i.n_lost));
      give_verdict();
   end
endmodule : test_contactless_poll_write_frames
